// File: shared/pad_state_cfg.svh
// constants for the suspend pad-state control block
`ifndef PAD_STATE_CFG_SVH
`define PAD_STATE_CFG_SVH
`define NUM_COLS 8
`define NUM_IRQ_COLS 5
`define IRQ_COL_FIRST 2
`define NUM_STROBES 6
`define RST_IR_RX_PD_EN 1'b1
`endif

// File: shared/pad_state_pkg.sv
// types for the suspend pad-state control block
package pad_state_pkg;
  // pad control for one pin
  typedef struct packed {
    logic oe;
    logic dout;
    logic pu_en;
    logic pd_en;
  } pad_ctl_s;
  // dram suspend mode
  typedef enum logic [1:0] {
    DRAM_CBR = 2'b00,
    DRAM_SELF = 2'b01,
    DRAM_OFF = 2'b11
  } dram_mode_e;
endpackage

// File: hw/pad_state_ctl.sv
// suspend pad-state control for keyboard, infrared and shared dram pins
`timescale 1ns/1ps
`default_nettype none
`include "pad_state_cfg.svh"
module pad_state_ctl
  import pad_state_pkg::*;
#(
  parameter int NUM_COLS = `NUM_COLS,
  parameter int NUM_STROBES = `NUM_STROBES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // status from power and dram units
  input wire logic suspend_in,
  input wire dram_mode_e dram_mode_in,
  input wire logic isa_group_off_in,
  // software configuration
  input wire logic ir_rx_pd_disable_in,
  input wire logic [NUM_COLS-1:0] col_pull_up_in,
  input wire logic [NUM_COLS-1:0] col_irq_sel_in,
  input wire logic irq_usage_flag_in,
  input wire logic [NUM_STROBES-1:0] strobe_en_in,
  input wire logic mem_addr_en_in,
  // functional drive values
  input wire logic ir_tx_data_in,
  input wire logic [NUM_COLS-1:0] col_drive_low_in,
  input wire logic [NUM_STROBES-1:0] strobe_data_in,
  input wire logic mem_addr_data_in,
  // pad controls
  output pad_ctl_s infrared_tx_out,
  output pad_ctl_s infrared_rx_out,
  output pad_ctl_s [NUM_COLS-1:0] col_pad_out,
  output pad_ctl_s [NUM_STROBES-1:0] strobe_pad_out,
  output pad_ctl_s mem_addr_pad_out
);

  // the interrupt-capable columns must exist
  if (NUM_COLS < `IRQ_COL_FIRST + `NUM_IRQ_COLS || NUM_STROBES < 1) begin : g_bad_params
    $error("pad_state_ctl: column or strobe count too small");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic ir_rx_pd_en;
    pad_ctl_s ir_tx;
    pad_ctl_s ir_rx;
    pad_ctl_s [NUM_COLS-1:0] col;
    pad_ctl_s [NUM_STROBES-1:0] strobe;
    pad_ctl_s maddr;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    // receive pulldown: on at reset, then software controlled
    state_nxt.ir_rx_pd_en = ~ir_rx_pd_disable_in;
    state_nxt.ir_rx = '{oe: 1'b0, dout: 1'b0, pu_en: 1'b0,
                        pd_en: state_nxt.ir_rx_pd_en};
    if (suspend_in) begin
      state_nxt.ir_tx = '{oe: 1'b0, dout: 1'b0, pu_en: 1'b0, pd_en: 1'b1};
    end else begin
      state_nxt.ir_tx = '{oe: 1'b1, dout: ir_tx_data_in, pu_en: 1'b0, pd_en: 1'b0};
    end
    for (int i = 0; i < NUM_COLS; i++) begin
      // only the interrupt-capable columns may become interrupt inputs
      if (col_irq_sel_in[i] && (i >= `IRQ_COL_FIRST)
          && (i < `IRQ_COL_FIRST + `NUM_IRQ_COLS)) begin
        // interrupt input, configured pull unless the suspend override forces pulldown
        state_nxt.col[i].oe = 1'b0;
        state_nxt.col[i].dout = 1'b0;
        if (suspend_in && isa_group_off_in && irq_usage_flag_in) begin
          state_nxt.col[i].pu_en = 1'b0;
          state_nxt.col[i].pd_en = 1'b1;
        end else begin
          state_nxt.col[i].pu_en = col_pull_up_in[i];
          state_nxt.col[i].pd_en = ~col_pull_up_in[i];
        end
      end else begin
        // open drain: enable only when pulling low
        state_nxt.col[i].oe = col_drive_low_in[i];
        state_nxt.col[i].dout = 1'b0;
        state_nxt.col[i].pu_en = col_pull_up_in[i];
        state_nxt.col[i].pd_en = ~col_pull_up_in[i];
      end
    end
    for (int j = 0; j < NUM_STROBES; j++) begin
      if (!strobe_en_in[j]) begin
        state_nxt.strobe[j] = '{oe: 1'b0, dout: 1'b0, pu_en: 1'b1, pd_en: 1'b0};
      end else if (!suspend_in || dram_mode_in == DRAM_CBR) begin
        state_nxt.strobe[j] = '{oe: 1'b1, dout: strobe_data_in[j],
                                pu_en: 1'b0, pd_en: 1'b0};
      end else if (dram_mode_in == DRAM_SELF) begin
        state_nxt.strobe[j] = '{oe: 1'b1, dout: 1'b0, pu_en: 1'b0, pd_en: 1'b0};
      end else begin
        state_nxt.strobe[j] = '{oe: 1'b0, dout: 1'b0, pu_en: 1'b0, pd_en: 1'b1};
      end
    end
    if (!mem_addr_en_in) begin
      state_nxt.maddr = '{oe: 1'b0, dout: 1'b0, pu_en: 1'b1, pd_en: 1'b0};
    end else if (suspend_in) begin
      state_nxt.maddr = '{oe: 1'b0, dout: 1'b0, pu_en: 1'b0, pd_en: 1'b1};
    end else begin
      state_nxt.maddr = '{oe: 1'b1, dout: mem_addr_data_in, pu_en: 1'b0, pd_en: 1'b0};
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_r <= '0;
      state_r.ir_rx_pd_en <= `RST_IR_RX_PD_EN;
      state_r.ir_rx.pd_en <= `RST_IR_RX_PD_EN;
      state_r.ir_tx.oe <= 1'b1;
      for (int i = 0; i < NUM_COLS; i++) begin
        state_r.col[i].pu_en <= 1'b1;
      end
      for (int j = 0; j < NUM_STROBES; j++) begin
        state_r.strobe[j].pu_en <= 1'b1;
      end
      state_r.maddr.pu_en <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign infrared_tx_out = state_r.ir_tx;
  assign infrared_rx_out = state_r.ir_rx;
  assign col_pad_out = state_r.col;
  assign strobe_pad_out = state_r.strobe;
  assign mem_addr_pad_out = state_r.maddr;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_suspend_cbr(int k);
    suspend_in && dram_mode_in == DRAM_CBR && strobe_en_in[k];
  endsequence

  a_ir_tx_float: assert property (suspend_in |=> !infrared_tx_out.oe && infrared_tx_out.pd_en)
    else $error("ir tx not floating with pulldown in suspend");
  a_ir_rx_pull: assert property (##1 infrared_rx_out.pd_en == !$past(ir_rx_pd_disable_in))
    else $error("ir rx pulldown mismatch");
  a_col_pull_dir: assert property (!col_irq_sel_in[0] |=>
      col_pad_out[0].pu_en == $past(col_pull_up_in[0]) && !col_pad_out[0].dout)
    else $error("column pull direction wrong");
  a_irq_col_input: assert property (col_irq_sel_in[2] && !suspend_in |=>
      !col_pad_out[2].oe && col_pad_out[2].pu_en == $past(col_pull_up_in[2]))
    else $error("irq column not an input with configured pull");
  a_irq_suspend_pd: assert property (col_irq_sel_in[3] && suspend_in && isa_group_off_in
      && irq_usage_flag_in |=> col_pad_out[3].pd_en && !col_pad_out[3].pu_en)
    else $error("irq column pulldown not forced");
  a_strobe_cbr: assert property (s_suspend_cbr(0) |=> strobe_pad_out[0].oe)
    else $error("strobe not driven under cbr refresh");
  a_strobe_self: assert property (suspend_in && dram_mode_in == DRAM_SELF && strobe_en_in[1]
      |=> strobe_pad_out[1].oe && !strobe_pad_out[1].dout)
    else $error("strobe not low under self refresh");
  a_strobe_off: assert property (suspend_in && dram_mode_in == DRAM_OFF && strobe_en_in[2]
      |=> !strobe_pad_out[2].oe && strobe_pad_out[2].pd_en)
    else $error("strobe not floating with pulldown");
  a_row_pullup: assert property (!strobe_en_in[3] |=> strobe_pad_out[3].pu_en
      && !strobe_pad_out[3].oe)
    else $error("row pin lost its pullup");
  a_maddr_float: assert property (suspend_in && mem_addr_en_in |=>
      !mem_addr_pad_out.oe && mem_addr_pad_out.pd_en)
    else $error("address pin not floating in suspend");
  a_no_dual_pull: assert property (!(col_pad_out[4].pu_en && col_pad_out[4].pd_en)
      && !(strobe_pad_out[4].pu_en && strobe_pad_out[4].pd_en))
    else $error("pullup and pulldown both on");

  // ------------------------------------------------------------
  // reset state assertions
  // ------------------------------------------------------------
  a_rx_pd_reset: assert property (disable iff (1'b0)
      srst_in |=> infrared_rx_out.pd_en && !infrared_rx_out.oe)
    else $error("ir rx pulldown off after reset");
  a_maddr_reset: assert property (disable iff (1'b0)
      srst_in |=> mem_addr_pad_out.pu_en && !mem_addr_pad_out.oe)
    else $error("address pin lost pullup in reset");
  a_tx_reset_low: assert property (disable iff (1'b0)
      srst_in |=> infrared_tx_out.oe && !infrared_tx_out.dout)
    else $error("ir tx not driven low in reset");

  // ------------------------------------------------------------
  // infrared and address pin assertions
  // ------------------------------------------------------------
  a_ir_tx_drive: assert property (!suspend_in |=>
      infrared_tx_out.oe && infrared_tx_out.dout == $past(ir_tx_data_in))
    else $error("ir tx not driving data in normal operation");
  a_ir_rx_input: assert property (!infrared_rx_out.oe && !infrared_rx_out.pu_en)
    else $error("ir rx not a plain input");
  a_ir_tx_pull: assert property (!infrared_tx_out.pu_en)
    else $error("ir tx pullup on");
  a_maddr_drive: assert property (!suspend_in && mem_addr_en_in |=>
      mem_addr_pad_out.oe && mem_addr_pad_out.dout == $past(mem_addr_data_in))
    else $error("address pin not driving data");
  a_maddr_row: assert property (!mem_addr_en_in |=>
      mem_addr_pad_out.pu_en && !mem_addr_pad_out.pd_en && !mem_addr_pad_out.oe)
    else $error("address pin as row lost pullup");
  a_maddr_pulls: assert property (!(mem_addr_pad_out.pu_en && mem_addr_pad_out.pd_en))
    else $error("address pin pulls both on");

  // ------------------------------------------------------------
  // per-column assertions
  // ------------------------------------------------------------
  for (genvar g = 0; g < NUM_COLS; g++) begin : g_col_chk
    localparam bit IRQ_OK = (g >= `IRQ_COL_FIRST) && (g < `IRQ_COL_FIRST + `NUM_IRQ_COLS);

    sequence s_col_override;
      col_irq_sel_in[g] && suspend_in && isa_group_off_in && irq_usage_flag_in;
    endsequence

    a_col_one_pull: assert property (!(col_pad_out[g].pu_en && col_pad_out[g].pd_en))
      else $error("column pulls both on");
    a_col_never_high: assert property (!col_pad_out[g].dout)
      else $error("column drives high");
    a_col_some_pull: assert property (col_pad_out[g].pu_en || col_pad_out[g].pd_en)
      else $error("column left without pull");
    if (IRQ_OK) begin : g_irq
      a_col_od_follow: assert property (!col_irq_sel_in[g] |=>
          col_pad_out[g].oe == $past(col_drive_low_in[g]))
        else $error("open-drain column enable wrong");
      a_irq_no_drive: assert property (col_irq_sel_in[g] |=> !col_pad_out[g].oe)
        else $error("interrupt column drives");
      a_irq_keep_pull: assert property (col_irq_sel_in[g] && !(suspend_in && isa_group_off_in
          && irq_usage_flag_in) |=> col_pad_out[g].pu_en == $past(col_pull_up_in[g]))
        else $error("interrupt column pull not kept");
      a_irq_force_pd: assert property (s_col_override |=>
          col_pad_out[g].pd_en && !col_pad_out[g].pu_en)
        else $error("interrupt column pulldown not forced");
    end else begin : g_plain
      a_col_ignores_irq: assert property (1'b1 |=>
          col_pad_out[g].oe == $past(col_drive_low_in[g]))
        else $error("plain column open-drain enable wrong");
      a_col_plain_pull: assert property (1'b1 |=>
          col_pad_out[g].pu_en == $past(col_pull_up_in[g]))
        else $error("plain column pull wrong");
    end
  end

  // ------------------------------------------------------------
  // per-strobe assertions
  // ------------------------------------------------------------
  for (genvar s = 0; s < NUM_STROBES; s++) begin : g_strobe_chk
    sequence s_strobe_suspend;
      strobe_en_in[s] && suspend_in;
    endsequence

    a_strobe_one_pull: assert property (!(strobe_pad_out[s].pu_en && strobe_pad_out[s].pd_en))
      else $error("strobe pulls both on");
    a_strobe_normal: assert property (strobe_en_in[s] && !suspend_in |=>
        strobe_pad_out[s].oe && strobe_pad_out[s].dout == $past(strobe_data_in[s]))
      else $error("strobe not driving data");
    a_strobe_cbr_data: assert property (s_strobe_suspend ##0 dram_mode_in == DRAM_CBR |=>
        strobe_pad_out[s].dout == $past(strobe_data_in[s]) && !strobe_pad_out[s].pd_en)
      else $error("strobe not active under cbr refresh");
    a_strobe_low: assert property (s_strobe_suspend ##0 dram_mode_in == DRAM_SELF |=>
        strobe_pad_out[s].oe && !strobe_pad_out[s].dout)
      else $error("strobe not low under self refresh");
    a_strobe_float: assert property (s_strobe_suspend ##0 dram_mode_in == DRAM_OFF |=>
        !strobe_pad_out[s].oe && strobe_pad_out[s].pd_en)
      else $error("strobe not floating with pulldown");
    a_strobe_row: assert property (!strobe_en_in[s] |=>
        strobe_pad_out[s].pu_en && !strobe_pad_out[s].oe && !strobe_pad_out[s].pd_en)
      else $error("row pin touched by dram settings");
  end

endmodule // pad_state_ctl
`default_nettype wire

// File: tb/key_matrix_model.sv
// key matrix side: resolves the column wire levels
`timescale 1ns/1ps
`default_nettype none
module key_matrix_model
  import pad_state_pkg::*;
(
  // clock
  input wire logic clk_in,
  // pad controls and wire levels
  input wire pad_ctl_s [7:0] col_pad_in,
  output logic [7:0] col_level_out
);
  logic [7:0] last_r;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (col_pad_in[i].oe) col_level_out[i] = col_pad_in[i].dout;
      else if (col_pad_in[i].pu_en) col_level_out[i] = 1'b1;
      else if (col_pad_in[i].pd_en) col_level_out[i] = 1'b0;
      else col_level_out[i] = ~last_r[i];
    end
  end
  always_ff @(posedge clk_in) last_r <= col_level_out;
endmodule // key_matrix_model
`default_nettype wire

// File: tb/suspend_pad_state_control_tb.sv
// self-checking bench for the suspend pad-state control block
`timescale 1ns/1ps
`default_nettype none
module suspend_pad_state_control_tb
  import pad_state_pkg::*;
();
  logic clk_in = 1'b0, srst_in = 1'b1, suspend_in = 1'b0, isa = 1'b0, rxd = 1'b0;
  logic flag = 1'b0, ma_en = 1'b0, tx_d = 1'b0, ma_d = 1'b0, ovr;
  dram_mode_e dram_mode_in = DRAM_CBR;
  logic [7:0] pull = 8'h00, irq = 8'h00, drv = 8'h00, lvl;
  logic [5:0] s_en = 6'h00, s_d = 6'h00;
  pad_ctl_s tx, rx, ma;
  pad_ctl_s [7:0] cols;
  pad_ctl_s [5:0] strb;
  int err_count = 0;
  int total_checks = 0;
  pad_state_ctl dut (.clk_in(clk_in), .srst_in(srst_in), .suspend_in(suspend_in),
    .dram_mode_in(dram_mode_in), .isa_group_off_in(isa), .ir_rx_pd_disable_in(rxd),
    .col_pull_up_in(pull), .col_irq_sel_in(irq), .irq_usage_flag_in(flag),
    .strobe_en_in(s_en), .mem_addr_en_in(ma_en), .ir_tx_data_in(tx_d),
    .col_drive_low_in(drv), .strobe_data_in(s_d), .mem_addr_data_in(ma_d),
    .infrared_tx_out(tx), .infrared_rx_out(rx), .col_pad_out(cols),
    .strobe_pad_out(strb), .mem_addr_pad_out(ma));
  key_matrix_model far (.clk_in(clk_in), .col_pad_in(cols), .col_level_out(lvl));
  always #4 clk_in = ~clk_in;
  task automatic step();
    @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input logic [3:0] msk);
    total_checks++;
    if ((got & msk) !== (exp & msk)) begin
      err_count++;
      $display("wrong value %0t %h %h", $time, got & msk, exp & msk);
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk_rst();
    chk(tx, 4'h8, 4'hc);
    chk(rx, 4'h1, 4'h3);
    for (int i = 0; i < 6; i++) chk(strb[i], 4'h2, 4'h3);
  endtask
  initial begin
    repeat (5) step();
    chk_rst();
    @(posedge clk_in);
    srst_in <= 1'b0;
    pull <= 8'h0f;
    drv <= 8'h55;
    irq <= 8'h7c;
    flag <= 1'b1;
    s_en <= 6'h15;
    s_d <= 6'h3f;
    ma_en <= 1'b1;
    ma_d <= 1'b1;
    tx_d <= 1'b1;
    rxd <= 1'b1;
    // normal first, then every suspend mode; isa group off in the normal step and in the override step
    for (int m = 4; m >= 0; m--) begin
      @(posedge clk_in);
      suspend_in <= (m < 4);
      dram_mode_in <= dram_mode_e'(m[1:0]);
      isa <= (m >= 3);
      step();
      for (int i = 0; i < 8; i++) begin
        ovr = (m == 3) && irq[i];
        if (irq[i]) chk(cols[i], {2'b00, pull[i] & ~ovr, ~pull[i] | ovr}, 4'hb);
        else chk(cols[i], {drv[i], 1'b0, pull[i], ~pull[i]}, 4'hf);
        chk({3'b000, lvl[i]}, {3'b000, pull[i] & ~ovr & ~(drv[i] & ~irq[i])}, 4'h1);
      end
      for (int i = 0; i < 6; i++) begin
        if (!s_en[i]) chk(strb[i], 4'h2, 4'h3);
        else if (m == 4 || m == 0) chk(strb[i], 4'hc, 4'hc);
        else if (m == 1) chk(strb[i], 4'h8, 4'hc);
        else chk(strb[i], 4'h1, 4'h9);
      end
      chk(tx, (m < 4) ? 4'h1 : 4'hc, (m < 4) ? 4'h9 : 4'hc);
      chk(ma, (m < 4) ? 4'h1 : 4'hc, (m < 4) ? 4'h9 : 4'hc);
      chk(rx, 4'h0, 4'h1);
    end
    // isa group off but usage flag clear: configured pulls stay
    @(posedge clk_in);
    flag <= 1'b0;
    isa <= 1'b1;
    step();
    for (int i = 2; i < 7; i++) chk(cols[i], {2'b00, pull[i], ~pull[i]}, 4'hb);
    @(posedge clk_in);
    srst_in <= 1'b1;
    step();
    chk_rst();
    conclude();
  end
  initial begin
    #20000;
    err_count++;
    conclude();
  end
endmodule // suspend_pad_state_control_tb
`default_nettype wire
